//--- rtl/epl_external_interrupt_pin_latch.sv
// What this block does
// - pin interrupt works only when the enable bit is one
// - detected requests stay latched until acknowledge, reset or clearing the enable bit
// - vector fetch of this interrupt pulses an acknowledge clearing the latch
// - writing one to the acknowledge bit clears the latch like a vector fetch
// - falling edge only after reset; mode bit adds low level triggering
// - reset clears latch and mode bit even with pin held low
// - mask bit set keeps the latched request from the priority logic
// - processor global interrupt mask blocks this request too
// - level mode: request ends only after pin high and acknowledge, any order
// - level mode: request stays pending while pin is low
// - a falling edge after acknowledge latches a new request
// - unmasked request taken makes the processor load this vector
// - edge mode: acknowledge clears the latch at once
// - pending flag readable regardless of the mask bit
// - pin level readable for the branch-if-pin-high and branch-if-pin-low tests
// - acknowledge bit is write-only and reads zero
// - with the function off the pin level tests see a one
// - block active in wait; unmasked request wakes the processor
`timescale 1ns/1ps
`default_nettype none

module epl_external_interrupt_pin_latch (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // avalon-mm slave
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // pin, active low
    input wire logic i_irq_pin_n,
    // processor side
    input wire logic i_vector_fetch,
    input wire logic i_condition_code_register_i_mask,
    input wire logic i_wait_mode,
    output logic o_interrupt_request,
    output logic o_wake_request,
    output logic o_branch_if_pin_high,
    output logic o_branch_if_pin_low,
    output logic o_port_a_bit_two_function
);

////////////////////////////////////////////////////////////////////////////////
// pin synchroniser

    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    logic next_pin_meta;
    logic next_pin_sync;
    logic next_pin_prev;

    // first flop may go metastable; only the second and third ones are read downstream
    // flops reset high, so a pin held low at release gives one fresh edge
    always_comb begin
        next_pin_meta = i_irq_pin_n;
        next_pin_sync = pin_meta;
        next_pin_prev = pin_sync;
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pin_meta <= epl_pkg::RESET_PIN_SYNC;
            pin_sync <= epl_pkg::RESET_PIN_SYNC;
            pin_prev <= epl_pkg::RESET_PIN_SYNC;
        end else begin
            pin_meta <= next_pin_meta;
            pin_sync <= next_pin_sync;
            pin_prev <= next_pin_prev;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// register bus

    logic mode;
    logic mask;
    logic enable;
    logic next_mode;
    logic next_mask;
    logic next_enable;

    logic [31:0] next_readdata;

    epl_pkg::epl_bus_state_type bus_state;
    epl_pkg::epl_bus_state_type next_bus_state;

    logic request_latch;
    logic sw_ack;
    logic access;
    logic bus_commit;
    logic lane_zero_write;

    // one wait cycle: request seen, answer given on the next edge
    assign access = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = access & (bus_state == epl_pkg::BUS_IDLE);
    assign bus_commit = access & (bus_state == epl_pkg::BUS_DONE);
    // only the low byte lane carries control bits; other lanes are ignored
    assign lane_zero_write = bus_commit & i_avs_write & i_avs_byteenable[0];

    // back to back accesses are fine: done always falls back to idle
    always_comb begin
        next_bus_state = epl_pkg::BUS_IDLE;
        unique case (bus_state)
            epl_pkg::BUS_IDLE: begin
                if (access) begin
                    next_bus_state = epl_pkg::BUS_DONE;
                end
            end
            epl_pkg::BUS_DONE: begin
                next_bus_state = epl_pkg::BUS_IDLE;
            end
            default: begin
                next_bus_state = epl_pkg::BUS_IDLE;
            end
        endcase
    end

////////////////////////////////////////////////////////////////////////////////
// control registers

    // writes land on the edge that ends the answer cycle
    // an ack bit is a one-cycle strobe, never stored
    always_comb begin
        next_mode = mode;
        next_mask = mask;
        next_enable = enable;
        sw_ack = 1'b0;
        if (lane_zero_write) begin
            if (i_avs_address == epl_pkg::ADDR_STATUS_CONTROL) begin
                next_mode = i_avs_writedata[epl_pkg::BIT_MODE];
                next_mask = i_avs_writedata[epl_pkg::BIT_MASK];
                sw_ack = i_avs_writedata[epl_pkg::BIT_ACK];
            end else if (i_avs_address == epl_pkg::ADDR_CONFIG) begin
                next_enable = i_avs_writedata[epl_pkg::BIT_ENABLE];
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// read data

    logic read_start;
    logic pin_level_seen;

    // captured in the wait cycle so the word stands at the edge that ends it
    assign read_start = i_avs_read & (bus_state == epl_pkg::BUS_IDLE);
    assign pin_level_seen = pin_sync | ~enable;

    always_comb begin
        next_readdata = o_avs_readdata;
        if (read_start) begin
            next_readdata = epl_pkg::READ_ZERO;
            unique case (i_avs_address)
                epl_pkg::ADDR_STATUS_CONTROL: begin
                    next_readdata[epl_pkg::BIT_MODE] = mode;
                    next_readdata[epl_pkg::BIT_MASK] = mask;
                    next_readdata[epl_pkg::BIT_PENDING] = request_latch;
                end
                epl_pkg::ADDR_CONFIG: begin
                    next_readdata[epl_pkg::BIT_ENABLE] = enable;
                end
                epl_pkg::ADDR_PIN_STATE: begin
                    next_readdata[epl_pkg::BIT_PIN_LEVEL] = pin_level_seen;
                end
                // unmapped offsets read as zero
                default: begin
                    next_readdata = epl_pkg::READ_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mode <= epl_pkg::RESET_MODE;
            mask <= epl_pkg::RESET_MASK;
            enable <= epl_pkg::RESET_ENABLE;
            o_avs_readdata <= epl_pkg::READ_ZERO;
            bus_state <= epl_pkg::BUS_IDLE;
        end else begin
            mode <= next_mode;
            mask <= next_mask;
            enable <= next_enable;
            o_avs_readdata <= next_readdata;
            bus_state <= next_bus_state;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// request latch

    logic ack;
    logic vector_ack;
    logic falling_edge;
    logic level_low;
    logic next_request_latch;

    // vector fetch only counts while this request is what the cpu serves;
    // a fetch for another source must not eat a pending pin request
    assign vector_ack = i_vector_fetch & o_interrupt_request;
    assign ack = sw_ack | vector_ack;

////////////////////////////////////////////////////////////////////////////////
// pin edge and level detection

    assign falling_edge = enable & pin_prev & ~pin_sync;
    assign level_low = enable & mode & ~pin_sync;

////////////////////////////////////////////////////////////////////////////////
// acknowledge held in level mode

    logic ack_held;
    logic next_ack_held;

    // an ack that lands while the pin is still low is remembered, so the
    // request ends as soon as the pin goes high, whichever came first
    always_comb begin
        next_ack_held = ack_held;
        if (!enable || !mode) begin
            next_ack_held = 1'b0;
        end else if (pin_sync) begin
            next_ack_held = 1'b0;
        end else if (ack) begin
            next_ack_held = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ack_held <= 1'b0;
        end else begin
            ack_held <= next_ack_held;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// latch update

    logic release_latch;

    assign release_latch = ack | (ack_held & pin_sync);

    // level mode re-latches every cycle the pin stays low, so software
    // must mask inside its handler or it is entered again at once
    always_comb begin
        next_request_latch = request_latch;
        if (release_latch) begin
            next_request_latch = 1'b0;
        end
        // set wins over a same-cycle ack so no pin event is lost
        if (level_low) begin
            next_request_latch = 1'b1;
        end
        if (falling_edge) begin
            next_request_latch = 1'b1;
        end
        if (!enable) begin
            next_request_latch = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            request_latch <= 1'b0;
        end else begin
            request_latch <= next_request_latch;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// processor side

    // global mask gates the request but never the pending flag
    assign o_interrupt_request = request_latch & ~mask & ~i_condition_code_register_i_mask;

    // wake ignores the global mask: the cpu must leave wait to see it at all
    assign o_wake_request = request_latch & ~mask & i_wait_mode;

    assign o_branch_if_pin_high = pin_level_seen;
    assign o_branch_if_pin_low = ~pin_level_seen;

    // high while the shared pin serves the port function
    assign o_port_a_bit_two_function = ~enable;

endmodule : epl_external_interrupt_pin_latch

`default_nettype wire

//--- rtl/epl_pkg.sv
package epl_pkg;
    // register map, byte addresses on the avalon word bus
    localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_CONFIG = 4'h4;
    localparam logic [3:0] ADDR_PIN_STATE = 4'h8;

    // status/control bit positions
    localparam int BIT_MODE = 0;
    localparam int BIT_MASK = 1;
    localparam int BIT_ACK = 2;
    localparam int BIT_PENDING = 3;
    // configuration bit positions
    localparam int BIT_ENABLE = 0;
    // pin state bit positions
    localparam int BIT_PIN_LEVEL = 0;

    // reset values
    localparam logic RESET_MODE = 1'h0;
    localparam logic RESET_MASK = 1'h0;
    localparam logic RESET_ENABLE = 1'h0;
    localparam logic RESET_PIN_SYNC = 1'h1;

    // unmapped reads return this
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_DONE = 2'b01
    } epl_bus_state_type;
endpackage : epl_pkg

//--- testbench/epl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module epl_monitor (
    input wire logic i_ref_clk, i_reset_n, i_avs_read, i_avs_write, o_avs_waitrequest, i_irq_pin_n,
    input wire logic i_vector_fetch, i_condition_code_register_i_mask, i_wait_mode, o_interrupt_request,
    input wire logic o_wake_request, o_branch_if_pin_high, o_branch_if_pin_low, o_port_a_bit_two_function
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    AST_GLOBAL_MASK: assert property (o_interrupt_request |-> !i_condition_code_register_i_mask)
        else $error("request while masked");
    AST_WAKE: assert property (o_wake_request |-> i_wait_mode)
        else $error("wake outside wait");
    AST_OFF: assert property (o_port_a_bit_two_function |-> o_branch_if_pin_high && !o_interrupt_request)
        else $error("function off but active");
    AST_PIN_PAIR: assert property (o_branch_if_pin_high != o_branch_if_pin_low)
        else $error("pin tests disagree");
    AST_SYNC: assert property ((!o_port_a_bit_two_function && !i_irq_pin_n)[*4] |-> !o_branch_if_pin_high)
        else $error("low pin not seen");
    AST_HOLD: assert property (o_interrupt_request && !i_vector_fetch && !i_avs_write
        && !($past(i_irq_pin_n, 2) && !$past(i_irq_pin_n, 3)) |=>
        o_interrupt_request || i_condition_code_register_i_mask) else $error("request dropped");
    AST_FETCH_CLEAR: assert property (i_irq_pin_n[*4] ##0 (i_vector_fetch && o_interrupt_request)
        |=> !o_interrupt_request) else $error("fetch left request");
    AST_ONE_WAIT: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("wait state count");
    cover property (i_vector_fetch && o_interrupt_request);
    cover property (o_wake_request);
    cover property (o_interrupt_request && !i_irq_pin_n);
endmodule : epl_monitor
bind epl_external_interrupt_pin_latch epl_monitor u_monitor (.*);
`default_nettype wire

//--- testbench/epl_pin_source.sv
`timescale 1ns/1ps
`default_nettype none
module epl_pin_source (
    input wire logic i_ref_clk,
    input wire logic i_assert,
    input wire logic [1:0] i_delay,
    output logic o_irq_pin_n
);
    // change i_delay only while the history is flat, else the pin may glitch
    logic [3:0] hist = 4'h0;
    always @(posedge i_ref_clk) hist <= {hist[2:0], i_assert};
    // released pin is pulled up, so idle reads high
    assign o_irq_pin_n = !hist[i_delay];
endmodule : epl_pin_source
`default_nettype wire

//--- testbench/tb_external_interrupt_pin_latch.sv
`timescale 1ns/1ps
`default_nettype none
module tb_external_interrupt_pin_latch;
    logic clk = 1'h0, rst_n = 1'h0, rd = 1'h0, wr_en = 1'h0, vf = 1'h0, gm = 1'h0, wm = 1'h0, req = 1'h0;
    logic [1:0] dly = 2'h0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wd = 32'h0, q, rdat;
    logic wq, irq, wake, branch_if_pin_high, branch_if_pin_low, paf, pin_n, mode = 1'h0, mask = 1'h0, lat = 1'h0;
    int bad_count = 0, tests_run = 0, cyc = 0, seed = 32'h09D0ED86;
    initial forever #12.5 clk = ~clk;
    epl_external_interrupt_pin_latch dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr_en), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
        .o_avs_readdata(q), .o_avs_waitrequest(wq), .i_irq_pin_n(pin_n), .i_vector_fetch(vf),
        .i_condition_code_register_i_mask(gm), .i_wait_mode(wm), .o_interrupt_request(irq),
        .o_wake_request(wake), .o_branch_if_pin_high(branch_if_pin_high), .o_branch_if_pin_low(branch_if_pin_low),
        .o_port_a_bit_two_function(paf));
    epl_pin_source src (.i_ref_clk(clk), .i_assert(req), .i_delay(dly), .o_irq_pin_n(pin_n));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        adr <= a; wd <= {24'($random(seed)), d}; rd <= !w; wr_en <= w;
        do @(posedge clk); while (wq !== 1'h0);
        rdat = q; rd <= 1'h0; wr_en <= 1'h0;
        @(posedge clk);
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [7:0] d); bus(1'h1, a, d); endtask : wr
    task automatic rdc(input logic [3:0] a, input logic [31:0] e); bus(1'h0, a, 8'h0); chk(rdat, e); endtask : rdc
    task automatic wt(input int n); repeat (n) @(posedge clk); endtask : wt
    // pin source delay plus two sync flops and the latch settle in 7 cycles, inside the 8 waited
    task automatic pin(input logic v); req <= v; wt(8); endtask : pin
    task automatic vfetch; vf <= 1'h1; wt(1); vf <= 1'h0; wt(1); endtask : vfetch
    function automatic logic [31:0] st; return {28'h0, lat, 1'h0, mask, mode}; endfunction : st
    task automatic fin(input int t); $display("test %0d done", t); endtask : fin
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            conclude;
        end
    end
    initial begin
        wt(5); rst_n <= 1'h1; wt(1);
        rdc(4'h0, st());
        rdc(4'h4, 32'h0); rdc(4'h8, 32'h1); rdc(4'hC, 32'h0);
        pin(1'h1); chk(branch_if_pin_high, 1'h1); chk(paf, 1'h1); chk(irq, 1'h0);
        pin(1'h0); fin(1);
        wr(4'h4, 8'h1); chk(paf, 1'h0);
        dly <= 2'($random(seed));
        pin(1'h1); lat = 1'h1; rdc(4'h0, st()); chk(irq, 1'h1);
        wr(4'h0, 8'h2); mask = 1'h1; chk(irq, 1'h0); rdc(4'h0, st());
        pin(1'h0); rdc(4'h0, st());
        wr(4'h0, 8'h6); lat = 1'h0; rdc(4'h0, st());
        wr(4'h0, 8'h0); mask = 1'h0; fin(2);
        pin(1'h1); lat = 1'h1; rdc(4'h8, 32'h0); chk(branch_if_pin_low, 1'h1);
        vfetch; lat = 1'h0; chk(irq, 1'h0); rdc(4'h0, st());
        pin(1'h0); pin(1'h1); lat = 1'h1; rdc(4'h0, st());
        wr(4'h0, 8'h4); lat = 1'h0; pin(1'h0); fin(3);
        wr(4'h0, 8'h1); mode = 1'h1; pin(1'h1); lat = 1'h1;
        wr(4'h0, 8'h5); rdc(4'h0, st());
        pin(1'h0); lat = 1'h0; rdc(4'h0, st());
        pin(1'h1); lat = 1'h1; wr(4'h0, 8'h3); mask = 1'h1;
        pin(1'h0); rdc(4'h0, st());
        wr(4'h0, 8'h7); lat = 1'h0; rdc(4'h0, st()); fin(4);
        wr(4'h0, 8'h1); mask = 1'h0; pin(1'h1); lat = 1'h1;
        gm <= 1'h1; wm <= 1'h1; wt(1); chk(irq, 1'h0); chk(wake, 1'h1);
        gm <= 1'h0; wm <= 1'h0; wt(1); chk(irq, 1'h1);
        rst_n <= 1'h0; wt(2); rst_n <= 1'h1; wt(1); mode = 1'h0; lat = 1'h0;
        rdc(4'h0, st()); rdc(4'h4, 32'h0); chk(irq, 1'h0);
        pin(1'h0); fin(5);
        wr(4'h4, 8'h1);
        for (int i = 0; i < 8; i++) begin
            dly <= 2'($random(seed));
            pin(1'h1); lat = 1'h1; rdc(4'h0, st());
            vfetch; lat = 1'h0; chk(irq, 1'h0);
            pin(1'h0);
        end
        fin(6);
        conclude;
    end
endmodule : tb_external_interrupt_pin_latch
`default_nettype wire
